//--- tb/amp_fault_protection_monitor_tb.sv
`timescale 1ns/1ps
module amp_fault_protection_monitor_tb;
  logic        clk;
  logic        rst_n;
  logic        gd_ok;
  logic        lg_ok;
  logic        warn;
  logic        thermal_shutdown_error;
  logic [1:0]  oc;
  logic [1:0]  mode;
  logic [3:0]  en;
  logic [3:0]  pd;
  logic        flt;
  logic        hw;
  logic        run;
  logic        running;
  logic [31:0] r;
  int          n_fail;
  int          check_count;
  int          seed;
  int          k;

  amp_prot_if bus ();
  amp_prot_device amp_prot_device_inst (.I_CORE_CLK(clk), .I_NRST(rst_n),
    .I_GATE_DRIVE_SUPPLY_OK(gd_ok), .I_LOGIC_SUPPLY_OK(lg_ok), .I_THERMAL_WARNING(warn),
    .I_THERMAL_SHUTDOWN_ERROR(thermal_shutdown_error), .I_OVERCURRENT_TRIP(oc), .I_MODE(mode),
    .O_BRIDGE_ENABLE(en), .O_WEAK_PULLDOWN(pd), .port(bus));
  amp_prot_host #(.BOOT_CYC(10), .OC_CYC(50)) amp_prot_host_inst (.I_CORE_CLK(clk),
    .I_NRST(rst_n), .I_RUN(run), .O_FAULT(flt), .O_THERMAL_WARNING(hw), .O_RUNNING(running),
    .port(bus));
  amp_prot_props #(.BOOT_CYC(10), .OC_CYC(50)) amp_prot_props_inst (.I_CORE_CLK(clk),
    .I_NRST(rst_n), .reset_n(bus.reset_n), .fault_n_o(bus.fault_n_o),
    .fault_n_oe(bus.fault_n_oe), .fault_n_line(bus.fault_n_line));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bounded wait on fault line or running flag
  task automatic wt(input int s, input logic v);
    for (int i = 0; i < 400; i++) begin
      if ((s ? running : bus.fault_n_line) === v) return;
      @(negedge clk);
    end
    n_fail++;
    $display("MISMATCH %0t wait timed out", $time);
    stop_test();
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 32'h1f6b;
    n_fail = 0;
    check_count = 0;
    {rst_n, warn, thermal_shutdown_error, oc, mode} = 7'h0;
    {gd_ok, lg_ok} = 2'h3;
    run = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    cmp(en, 4'h0);
    wt(1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      k = int'(r[5:3]) % 5;
      warn = r[0];
      mode = r[2:1];
      gd_ok = (k != 1);
      lg_ok = (k != 2);
      thermal_shutdown_error = (k == 3);
      oc = (k == 4) ? {r[7], ~r[7] | r[6]} : 2'h0;
      if (k == 0) begin
        repeat (8) @(negedge clk);
        cmp(en, 4'hf);
        cmp({2'h0, bus.fault_n_line, bus.thermal_warning_flag}, {3'h1, warn});
        cmp({2'h0, flt, hw}, {3'h0, warn});
      end else begin
        wt(0, 1'b0);
        cmp(en, 4'h0);
        cmp({2'h0, bus.fault_n_line, bus.thermal_warning_flag}, {3'h0, warn});
        {gd_ok, lg_ok, thermal_shutdown_error, oc} = 5'h18;
        repeat (3) @(negedge clk);
        cmp(en, (k < 3) ? 4'hf : 4'h0);
        wt(1, 1'b0);
        repeat (6) @(negedge clk);
        cmp(en, 4'h0);
        cmp(pd, (mode == 2'h2) ? 4'h0 : 4'hf);
        wt(1, 1'b1);
        repeat (4) @(negedge clk);
        cmp(en, 4'hf);
      end
    end
    run = 1'b0;
    wt(1, 1'b0);
    repeat (4) @(negedge clk);
    cmp({3'h0, bus.reset_n}, 4'h0);
    cmp(en, 4'h0);
    run = 1'b1;
    wt(1, 1'b1);
    repeat (4) @(negedge clk);
    cmp(en, 4'hf);
    stop_test();
  end
endmodule // amp_fault_protection_monitor_tb

//--- tb/amp_prot_props.sv
`timescale 1ns/1ps
module amp_prot_props #(
  parameter int unsigned BOOT_CYC = 10,
  parameter int unsigned OC_CYC   = 50
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // interface signals
  input wire logic reset_n,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic fault_n_line
);
  logic [31:0] lo_cnt_q;
  logic        flt_q;

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  // cycles spent in reset
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) lo_cnt_q <= 32'h0;
    else lo_cnt_q <= reset_n ? 32'h0 : lo_cnt_q + 32'h1;
  end

  // fault seen before reset
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) flt_q <= 1'b0;
    else if (reset_n) flt_q <= !fault_n_line;
  end

  sequence s_fault_seen;
    reset_n && !fault_n_line;
  endsequence
  sequence s_restart;
    $rose(reset_n);
  endsequence

  chk_od_drive_low: assert property (
    fault_n_oe |-> !fault_n_o) else $error("fault line driven high");
  chk_od_release: assert property (
    !fault_n_oe |-> fault_n_line) else $error("released line not high");
  chk_rst_frees_oe: assert property (
    (!reset_n)[*4] |-> !fault_n_oe) else $error("fault driven in reset");
  chk_rst_line_high: assert property (
    (!reset_n)[*4] |-> fault_n_line) else $error("fault line low in reset");
  chk_host_mutes: assert property (
    s_fault_seen ##1 s_fault_seen |-> ##[0:4] !reset_n) else $error("host kept running");
  chk_boot_hold: assert property (
    s_restart |-> lo_cnt_q >= BOOT_CYC) else $error("reset too short");
  chk_oc_wait: assert property (
    s_restart ##0 flt_q |-> lo_cnt_q >= OC_CYC) else $error("recovery too soon");
  chk_rise_quiet: assert property (
    s_restart |-> fault_n_line[*2]) else $error("fault before reset seen");
endmodule // amp_prot_props

//--- verilog/amp_prot_device.sv
`timescale 1ns/1ps
// Operation
// - outputs hi-z until both supplies valid
// - weak pulldown in reset unless single-ended
// - host holds reset 200 us at power-up
// - host asserts reset before supply removal
// - keep running while supplies stay valid
// - fault indicator is active-low open-drain
// - thermal warning is push-pull active-high
// - fault low on any shutdown fault
// - warning high above 125 C
// - flag pair encodes normal, warning, faults
// - reset forces fault indicator released
// - host reacts to thermal warning; the host here only passes it to O_THERMAL_WARNING and keeps running
// - any fault sets stage hi-z immediately
// - other faults recover automatically
// - host resets no sooner than 300 ms
// - thermal shutdown latched until reset
// - reset low forces all bridges hi-z
// - overcurrent latch cleared on reset rise
// - overcurrent shuts all four bridges
module amp_prot_device (
  // clock and reset
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_NRST,
  // analog monitor comparators and mode pins
  input  wire logic       I_GATE_DRIVE_SUPPLY_OK,
  input  wire logic       I_LOGIC_SUPPLY_OK,
  input  wire logic       I_THERMAL_WARNING,
  input  wire logic       I_THERMAL_SHUTDOWN_ERROR,
  input  wire logic [1:0] I_OVERCURRENT_TRIP,
  input  wire logic [1:0] I_MODE,
  // power stage control
  output logic      [3:0] O_BRIDGE_ENABLE,
  output logic      [3:0] O_WEAK_PULLDOWN,
  // host side
  amp_prot_if.device      port
);
  logic [1:0] gd_s;
  logic [1:0] lg_s;
  logic [1:0] tw_s;
  logic [1:0] te_s;
  logic [1:0] rst_s;
  logic [1:0] oc0_s;
  logic [1:0] oc1_s;
  logic [1:0] md0_s;
  logic [1:0] md1_s;
  logic       rst_q;
  logic       oc_latch_q;
  logic       te_latch_q;
  logic       fault_drive_q;
  logic       tw_q;
  logic       uv;
  logic       oc_any;
  logic       rst_rise;
  logic       shutdown;
  logic       stage_off;

  // same level on all four half-bridges
  function automatic logic [3:0] bridge_mask(input logic on);
    return on ? amp_prot_pkg::ALL_BRIDGES : amp_prot_pkg::NO_BRIDGES;
  endfunction

  // either pair reports overcurrent
  function automatic logic trip_any(input logic [1:0] trips);
    return trips[0] || trips[1];
  endfunction

  // mode pins select single-ended wiring
  function automatic logic is_single_ended(input logic [1:0] mode);
    return mode == amp_prot_pkg::MODE_SINGLE_ENDED;
  endfunction

  // gate-drive supply comparator, two flops
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      gd_s <= 2'h0;
    end else begin
      gd_s <= {gd_s[0], I_GATE_DRIVE_SUPPLY_OK};
    end
  end

  // logic supply comparator, two flops
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lg_s <= 2'h0;
    end else begin
      lg_s <= {lg_s[0], I_LOGIC_SUPPLY_OK};
    end
  end

  // thermal warning comparator, two flops
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tw_s <= 2'h0;
    end else begin
      tw_s <= {tw_s[0], I_THERMAL_WARNING};
    end
  end

  // thermal shutdown comparator, two flops
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      te_s <= 2'h0;
    end else begin
      te_s <= {te_s[0], I_THERMAL_SHUTDOWN_ERROR};
    end
  end

  // reset pin, two flops
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_s <= 2'h0;
    end else begin
      rst_s <= {rst_s[0], port.reset_n};
    end
  end

  // overcurrent comparators, one per pair
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oc0_s <= 2'h0;
      oc1_s <= 2'h0;
    end else begin
      oc0_s <= {oc0_s[0], I_OVERCURRENT_TRIP[0]};
      oc1_s <= {oc1_s[0], I_OVERCURRENT_TRIP[1]};
    end
  end

  // mode pins, two flops each
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      md0_s <= 2'h0;
      md1_s <= 2'h0;
    end else begin
      md0_s <= {md0_s[0], I_MODE[0]};
      md1_s <= {md1_s[0], I_MODE[1]};
    end
  end

  assign uv = !gd_s[1] || !lg_s[1];

  assign oc_any = trip_any({oc1_s[1], oc0_s[1]});

  // previous reset level for edge detect
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= rst_s[1];
    end
  end

  // rising edge of synchronised reset
  assign rst_rise = rst_s[1] && !rst_q;

  // overcurrent latch, rising reset clears, trip wins
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oc_latch_q <= 1'b0;
    end else if (oc_any) begin
      oc_latch_q <= 1'b1;
    end else if (rst_rise) begin
      oc_latch_q <= 1'b0;
    end
  end

  // thermal shutdown latch, reset low clears
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      te_latch_q <= 1'b0;
    end else if (te_s[1]) begin
      te_latch_q <= 1'b1;
    end else if (!rst_s[1]) begin
      te_latch_q <= 1'b0;
    end
  end

  // shutdown from any fault; uv self-clears
  assign shutdown = uv || oc_latch_q || te_latch_q || oc_any || te_s[1];

  // fault forces hi-z; reset low is hard mute
  assign stage_off = shutdown || !rst_s[1];

  // all four bridges together; else run
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BRIDGE_ENABLE <= amp_prot_pkg::NO_BRIDGES;
    end else begin
      O_BRIDGE_ENABLE <= bridge_mask(!stage_off);
    end
  end

  // pulldown only in reset, not single-ended
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WEAK_PULLDOWN <= amp_prot_pkg::NO_BRIDGES;
    end else begin
      O_WEAK_PULLDOWN <= bridge_mask(!rst_s[1] && !is_single_ended({md1_s[1], md0_s[1]}));
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      fault_drive_q <= 1'b0;
    end else begin
      fault_drive_q <= shutdown && rst_s[1];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tw_q <= 1'b0;
    end else begin
      tw_q <= tw_s[1];
    end
  end

  assign port.fault_n_o  = 1'b0;
  assign port.fault_n_oe = fault_drive_q;
  assign port.thermal_warning_flag = tw_q;
endmodule // amp_prot_device

//--- verilog/amp_prot_host.sv
`timescale 1ns/1ps
module amp_prot_host #(
  parameter int unsigned BOOT_CYC = amp_prot_pkg::BOOT_CHARGE_CYC,
  parameter int unsigned OC_CYC   = amp_prot_pkg::OC_WAIT_CYC
) (
  // clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_NRST,
  // user control
  input  wire logic I_RUN,
  // user status
  output logic      O_FAULT,
  output logic      O_THERMAL_WARNING,
  output logic      O_RUNNING,
  // device side
  amp_prot_if.host  port
);
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_WAIT} host_state_e;
  host_state_e                    state_q;
  logic [1:0]                     f_s, w_s;
  logic [amp_prot_pkg::CNT_W-1:0] cnt_q;
  logic                           rst_q;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      f_s <= 2'h3;
      w_s <= 2'h0;
    end else begin
      f_s <= {f_s[0], port.fault_n_line};
      w_s <= {w_s[0], port.thermal_warning_flag};
    end
  end

  // hold reset at power-up; assert when not run
  // wait after fault before releasing; counter
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= ST_HOLD;
      cnt_q   <= '0;
      rst_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          rst_q <= 1'b0;
          if (cnt_q < BOOT_CYC[amp_prot_pkg::CNT_W-1:0]) begin
            cnt_q <= cnt_q + 1'b1;
          end else if (I_RUN) begin
            state_q <= ST_RUN;
            rst_q   <= 1'b1;
          end
        end
        ST_RUN: begin
          if (!I_RUN) begin
            state_q <= ST_HOLD;
            rst_q   <= 1'b0;
            cnt_q   <= '0;
          end else if (!f_s[1]) begin
            state_q <= ST_WAIT;
            rst_q   <= 1'b0;
            cnt_q   <= '0;
          end
        end
        ST_WAIT: begin
          rst_q <= 1'b0;
          if (cnt_q < OC_CYC[amp_prot_pkg::CNT_W-1:0]) begin
            cnt_q <= cnt_q + 1'b1;
          end else begin
            state_q <= ST_HOLD;
            cnt_q   <= '0;
          end
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // user status, registered
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FAULT           <= 1'b0;
      O_THERMAL_WARNING <= 1'b0;
      O_RUNNING         <= 1'b0;
    end else begin
      O_THERMAL_WARNING <= w_s[1];
      O_FAULT           <= !f_s[1];
      O_RUNNING         <= (state_q == ST_RUN);
    end
  end

  assign port.reset_n = rst_q;
endmodule // amp_prot_host

//--- verilog/amp_prot_if.sv
`timescale 1ns/1ps
interface amp_prot_if;
  logic reset_n;
  logic fault_n_o;
  logic fault_n_oe;
  logic thermal_warning_flag;
  // open-drain line with pullup
  wire  fault_n_line = fault_n_oe ? fault_n_o : 1'b1;

  modport device (
    input  reset_n,
    output fault_n_o,
    output fault_n_oe,
    output thermal_warning_flag
  );
  modport host (
    output reset_n,
    input  fault_n_line,
    input  thermal_warning_flag
  );
endinterface

//--- verilog/amp_prot_pkg.sv
package amp_prot_pkg;
  // clock rate
  localparam int unsigned CLK_PERIOD_NS     = 10;
  // bootstrap charge hold in reset, microseconds
  localparam int unsigned BOOT_CHARGE_US    = 200;
  localparam int unsigned BOOT_CHARGE_CYC   = (BOOT_CHARGE_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  // overcurrent recovery wait, milliseconds
  localparam int unsigned OC_WAIT_MS        = 300;
  localparam int unsigned OC_WAIT_CYC       = (OC_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  // mode pins selecting single-ended operation
  localparam logic [1:0]  MODE_SINGLE_ENDED = 2'h2;
  // number of half-bridges
  localparam int unsigned N_BRIDGE          = 4;
  localparam logic [3:0]  ALL_BRIDGES       = 4'hf;
  localparam logic [3:0]  NO_BRIDGES        = 4'h0;
  // counter width for long waits
  localparam int unsigned CNT_W             = 32;
endpackage
